// >>> core/smc_pkg.sv
// Constants shared by the static memory bank controller.
package smc_pkg;
    localparam int NBANK = 8;
    localparam logic [31:0] WIN_BASE = 32'h4000_0000;
    localparam logic [31:0] WIN_LAST = 32'h5fff_ffff;
    localparam int WIN_SHIFT = 26;
    localparam logic [11:0] BANK_STRIDE = 12'h01c;
    localparam logic [11:0] OFF_IDLE = 12'h000;
    localparam logic [11:0] OFF_RDWAIT = 12'h004;
    localparam logic [11:0] OFF_WRWAIT = 12'h008;
    localparam logic [11:0] OFF_OEDLY = 12'h00c;
    localparam logic [11:0] OFF_WEDLY = 12'h010;
    localparam logic [11:0] OFF_CFG = 12'h014;
    localparam logic [11:0] OFF_STAT = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h0e0;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h0e4;
    localparam logic [3:0] RST_IDLE = 4'hf;
    localparam logic [4:0] RST_WAIT = 5'h1f;
    localparam logic [3:0] RST_OEDLY = 4'h0;
    localparam logic [3:0] RST_WEDLY = 4'h1;
    localparam logic [7:0] RST_CFG_B0 = 8'h80;
    localparam logic [7:0] RST_CFG_B1 = 8'h00;
    localparam logic [7:0] RST_CFG_B2 = 8'h40;
    localparam logic [7:0] RST_CFG_OTHER = 8'h00;
    // Configuration fields.
    localparam int CFG_LANE_BIT = 0;
    localparam int CFG_WP_BIT = 3;
    localparam int CFG_WIDTH_LO = 6;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam int STAT_WPERR_BIT = 1;
    localparam int ADDR_W = 26;
endpackage

// >>> core/static_memory_bank_controller.sv
// Static memory bank controller: APB registers, system port, memory pins.
// Behaviour
// - Eight banks each hold their own configuration and all stay usable.
// - Banks decode fixed 64 MB windows from 0x4000_0000 to 0x5fff_ffff.
// - Any bank may serve SRAM, ROM, flash, burst ROM or mapped I/O.
// - A width field per bank selects 8, 16 or 32 bit external data.
// - The byte-lane mode bit is 0 for 8-bit parts and 1 for wider parts.
// - 32-bit banks drop A0 and A1, 16-bit banks drop A0, 8-bit use A0.
// - Eight bank selects, four byte-lane selects, a write and read strobe.
// - A write-protected bank never sees a write strobe.
// - A write to a protected bank sets that bank's protect error flag.
// - Reads and writes have their own programmable wait-state counts.
// - Idle turn-around cycles separate a read from a following write to the same bank.
// - Idle count 4 bits reset 0xf, wait counts 5 bits reset 0x1f.
// - Read strobe delay resets to 0, write strobe delay resets to 1.
// - Configuration resets to 0x80, 0x00, 0x40 for banks 0, 1, 2.
`timescale 1ns/1ps
`default_nettype none
module static_memory_bank_controller
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             irq,
    input  wire logic        sys_req,
    input  wire logic        sys_write,
    input  wire logic [31:0] sys_addr,
    input  wire logic [3:0]  sys_be,
    input  wire logic [31:0] sys_wdata,
    output logic             sys_done,
    output logic             sys_err,
    output logic [31:0]      sys_rdata,
    output logic [7:0]       mem_cs_n,
    output logic [3:0]       byte_lane_select_n,
    output logic             mem_we_n,
    output logic             mem_oe_n,
    output logic [25:0]      mem_addr,
    output logic [31:0]      mem_dout,
    output logic             mem_doe,
    input  wire logic [31:0] mem_din
);
    typedef enum logic [2:0] {S_IDLE, S_TURN, S_LEAD, S_STROBE, S_NEXT,
                              S_DONE} state_t;

    logic [3:0] idle_r   [8];
    logic [4:0] rdwait_r [8];
    logic [4:0] wrwait_r [8];
    logic [3:0] oedly_r  [8];
    logic [3:0] wedly_r  [8];
    logic [7:0] cfg_r    [8];
    logic [7:0] wperr_r;
    logic [7:0] irq_mask_r;
    state_t     state_r;
    logic [2:0] bank_r;
    logic [4:0] cnt_r;
    logic [1:0] part_r;
    logic [1:0] nparts_r;
    logic       last_rd_r;
    logic [2:0] last_bank_r;
    logic [31:0] rbuf_r;

    logic       apb_wr;
    logic       apb_rd;
    logic [2:0] reg_bank;
    logic [11:0] reg_off;
    logic       in_bank_area;
    logic       in_win;
    logic [2:0] sel_bank;
    logic [1:0] width;
    logic [1:0] parts_need;
    logic       wp_hit;
    logic [3:0] lanes;
    logic [7:0] wperr_set;

    assign apb_wr = psel && penable && pwrite && clk_en;
    assign apb_rd = psel && !pwrite;
    assign reg_bank = 3'(paddr / smc_pkg::BANK_STRIDE);
    assign reg_off = paddr - 12'(reg_bank) * smc_pkg::BANK_STRIDE;
    assign in_bank_area = paddr < 12'(smc_pkg::NBANK) * smc_pkg::BANK_STRIDE;
    assign pready = 1'b1;

    assign in_win = sys_addr >= smc_pkg::WIN_BASE
                    && sys_addr <= smc_pkg::WIN_LAST;
    assign sel_bank = 3'((sys_addr - smc_pkg::WIN_BASE) >> smc_pkg::WIN_SHIFT);
    assign width = cfg_r[bank_r][smc_pkg::CFG_WIDTH_LO +: 2];
    always_comb
    begin
        case (cfg_r[sel_bank][smc_pkg::CFG_WIDTH_LO +: 2])
            smc_pkg::WIDTH_8:  parts_need = 2'd3;
            smc_pkg::WIDTH_16: parts_need = 2'd1;
            default:           parts_need = 2'd0;
        endcase
    end
    assign wp_hit = sys_write && cfg_r[sel_bank][smc_pkg::CFG_WP_BIT];

    // Bytes of the word that the current part carries, by bank width.
    always_comb
    begin
        case (width)
            smc_pkg::WIDTH_8:  lanes = 4'(sys_be[part_r]);
            smc_pkg::WIDTH_16: lanes = part_r[0] ? {2'b00, sys_be[3:2]}
                                                 : {2'b00, sys_be[1:0]};
            default:           lanes = sys_be;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < smc_pkg::NBANK; g++)
        begin : g_bank
            localparam logic [7:0] CFG_RST =
                (g == 0) ? smc_pkg::RST_CFG_B0 :
                (g == 1) ? smc_pkg::RST_CFG_B1 :
                (g == 2) ? smc_pkg::RST_CFG_B2 : smc_pkg::RST_CFG_OTHER;
            logic hit;
            assign hit = apb_wr && in_bank_area && reg_bank == 3'(g);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    idle_r[g]   <= smc_pkg::RST_IDLE;
                    rdwait_r[g] <= smc_pkg::RST_WAIT;
                    wrwait_r[g] <= smc_pkg::RST_WAIT;
                    oedly_r[g]  <= smc_pkg::RST_OEDLY;
                    wedly_r[g]  <= smc_pkg::RST_WEDLY;
                    cfg_r[g]    <= CFG_RST;
                end
                else if (hit)
                begin
                    case (reg_off)
                        smc_pkg::OFF_IDLE:   idle_r[g]   <= pwdata[3:0];
                        smc_pkg::OFF_RDWAIT: rdwait_r[g] <= pwdata[4:0];
                        smc_pkg::OFF_WRWAIT: wrwait_r[g] <= pwdata[4:0];
                        smc_pkg::OFF_OEDLY:  oedly_r[g]  <= pwdata[3:0];
                        smc_pkg::OFF_WEDLY:  wedly_r[g]  <= pwdata[3:0];
                        smc_pkg::OFF_CFG:    cfg_r[g]    <= pwdata[7:0];
                        default:             ;
                    endcase
                end
            end
            assign wperr_set[g] = state_r == S_IDLE && sys_req && in_win
                                  && wp_hit && sel_bank == 3'(g) && clk_en;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    wperr_r[g] <= 1'b0;
                else if (wperr_set[g])
                    wperr_r[g] <= 1'b1;
                else if (clk_en && ((hit && reg_off == smc_pkg::OFF_STAT
                         && pwdata[smc_pkg::STAT_WPERR_BIT])
                         || (apb_wr && paddr == smc_pkg::OFF_IRQ_STAT
                         && pwdata[g])))
                    wperr_r[g] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_r <= 8'h00;
        else if (apb_wr && paddr == smc_pkg::OFF_IRQ_MASK)
            irq_mask_r <= pwdata[7:0];
    end
    assign irq = |(wperr_r & irq_mask_r);

    // Reads answer in the access phase; unmapped offsets give pslverr.
    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (in_bank_area)
        begin
            case (reg_off)
                smc_pkg::OFF_IDLE:   prdata = 32'(idle_r[reg_bank]);
                smc_pkg::OFF_RDWAIT: prdata = 32'(rdwait_r[reg_bank]);
                smc_pkg::OFF_WRWAIT: prdata = 32'(wrwait_r[reg_bank]);
                smc_pkg::OFF_OEDLY:  prdata = 32'(oedly_r[reg_bank]);
                smc_pkg::OFF_WEDLY:  prdata = 32'(wedly_r[reg_bank]);
                smc_pkg::OFF_CFG:    prdata = 32'(cfg_r[reg_bank]);
                smc_pkg::OFF_STAT:   prdata = 32'({wperr_r[reg_bank], 1'b0});
                default:             pslverr = psel && penable;
            endcase
        end
        else if (paddr == smc_pkg::OFF_IRQ_MASK)
            prdata = 32'(irq_mask_r);
        else if (paddr == smc_pkg::OFF_IRQ_STAT)
            prdata = 32'(wperr_r);
        else
            pslverr = psel && penable;
        if (!apb_rd)
            prdata = 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r     <= S_IDLE;
            bank_r      <= 3'd0;
            cnt_r       <= 5'd0;
            part_r      <= 2'd0;
            nparts_r    <= 2'd0;
            last_rd_r   <= 1'b0;
            last_bank_r <= 3'd0;
        end
        else if (clk_en)
        begin
            case (state_r)
                S_IDLE:
                    if (sys_req && in_win && !wp_hit)
                    begin
                        bank_r   <= sel_bank;
                        part_r   <= 2'd0;
                        nparts_r <= parts_need;
                        if (sys_write && last_rd_r && last_bank_r == sel_bank)
                        begin
                            cnt_r   <= 5'(idle_r[sel_bank]);
                            state_r <= S_TURN;
                        end
                        else
                        begin
                            cnt_r <= sys_write ? 5'(wedly_r[sel_bank])
                                               : 5'(oedly_r[sel_bank]);
                            state_r <= S_LEAD;
                        end
                    end
                    else if (sys_req)
                        state_r <= S_DONE;
                S_TURN:
                    if (cnt_r == 5'd0)
                    begin
                        cnt_r   <= 5'(wedly_r[bank_r]);
                        state_r <= S_LEAD;
                    end
                    else
                        cnt_r <= cnt_r - 5'd1;
                S_LEAD:
                    if (cnt_r == 5'd0)
                    begin
                        cnt_r   <= sys_write ? wrwait_r[bank_r]
                                             : rdwait_r[bank_r];
                        state_r <= S_STROBE;
                    end
                    else
                        cnt_r <= cnt_r - 5'd1;
                S_STROBE:
                    if (cnt_r == 5'd0)
                        state_r <= S_NEXT;
                    else
                        cnt_r <= cnt_r - 5'd1;
                S_NEXT:
                begin
                    last_rd_r   <= !sys_write;
                    last_bank_r <= bank_r;
                    if (part_r == nparts_r)
                        state_r <= S_DONE;
                    else
                    begin
                        part_r  <= part_r + 2'd1;
                        cnt_r   <= sys_write ? 5'(wedly_r[bank_r])
                                             : 5'(oedly_r[bank_r]);
                        state_r <= S_LEAD;
                    end
                end
                S_DONE:
                    state_r <= S_IDLE;
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    // Read data is taken one step after the strobe: the read strobe is a
    // registered pin, so only then has it been low for a whole cycle, even
    // with a wait count of zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rbuf_r <= 32'h0000_0000;
        else if (clk_en && state_r == S_NEXT && !sys_write)
        begin
            case (width)
                smc_pkg::WIDTH_8:  rbuf_r[8*part_r +: 8] <= mem_din[7:0];
                smc_pkg::WIDTH_16: rbuf_r[16*part_r[0] +: 16] <= mem_din[15:0];
                default:           rbuf_r <= mem_din;
            endcase
        end
    end
    assign sys_rdata = rbuf_r;
    assign sys_done  = state_r == S_DONE;
    assign sys_err   = state_r == S_DONE && !(in_win && !wp_hit);

    // Pin outputs registered so strobes are glitch free.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_cs_n           <= 8'hff;
            byte_lane_select_n <= 4'hf;
            mem_we_n           <= 1'b1;
            mem_oe_n           <= 1'b1;
            mem_addr           <= 26'h0000000;
            mem_dout           <= 32'h0000_0000;
            mem_doe            <= 1'b0;
        end
        else if (clk_en)
        begin
            mem_cs_n <= 8'hff;
            byte_lane_select_n <= 4'hf;
            mem_we_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_doe  <= 1'b0;
            if (state_r == S_LEAD || state_r == S_STROBE)
            begin
                mem_cs_n[bank_r] <= 1'b0;
                mem_doe <= sys_write;
                case (width)
                    smc_pkg::WIDTH_8:  mem_addr <= {sys_addr[25:2], part_r};
                    smc_pkg::WIDTH_16: mem_addr <= {sys_addr[25:2], part_r[0],
                                                    1'b0};
                    default:           mem_addr <= {sys_addr[25:2], 2'b00};
                endcase
                case (width)
                    smc_pkg::WIDTH_8:  mem_dout <= 32'(sys_wdata[8*part_r
                                                      +: 8]);
                    smc_pkg::WIDTH_16: mem_dout <= 32'(sys_wdata[16*part_r[0]
                                                      +: 16]);
                    default:           mem_dout <= sys_wdata;
                endcase
                if (state_r == S_STROBE)
                begin
                    mem_we_n <= !(sys_write
                                  && !cfg_r[bank_r][smc_pkg::CFG_WP_BIT]);
                    mem_oe_n <= sys_write;
                    // lanes follow the mode bit on reads
                    byte_lane_select_n <= (sys_write ||
                        cfg_r[bank_r][smc_pkg::CFG_LANE_BIT]) ? ~lanes : 4'hf;
                end
            end
        end
    end
    // no device type restriction: timing alone is programmed.
endmodule // static_memory_bank_controller
`default_nettype wire

// >>> sim/sram_model.sv
// Behavioural asynchronous memory sitting on the external bus pins.
`timescale 1ns/1ps
`default_nettype none
module sram_model
(
    input  wire logic        pclk,
    input  wire logic [7:0]  mem_cs_n,
    input  wire logic [3:0]  byte_lane_select_n,
    input  wire logic        mem_we_n,
    input  wire logic        mem_oe_n,
    input  wire logic [25:0] mem_addr,
    input  wire logic [31:0] mem_dout,
    output logic      [31:0] mem_din
);
    logic [31:0] store [bit [33:0]];
    logic [31:0] last_r = 32'h0;
    logic [31:0] w;
    bit   [33:0] key;
    assign key = {mem_cs_n, mem_addr};
    always @(posedge pclk)
    begin
        if (mem_we_n === 1'b0 && mem_cs_n != 8'hff)
        begin
            w = store.exists(key) ? store[key] : 32'h0;
            for (int i = 0; i < 4; i++)
                if (!byte_lane_select_n[i])
                    w[8*i+:8] = mem_dout[8*i+:8];
            store[key] = w;
        end
    end
    // A released bus toggles so a late sample never sees stale data.
    always @(*)
    begin
        if (mem_oe_n === 1'b0 && mem_cs_n != 8'hff)
            mem_din = store.exists(key) ? store[key] : 32'h0;
        else
            mem_din = ~last_r;
    end
    always @(posedge pclk)
        last_r <= mem_din;
endmodule // sram_model
`default_nettype wire

// >>> sim/smc_checker.sv
// Port assertions for the static memory bank controller.
`timescale 1ns/1ps
`default_nettype none
module smc_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        sys_req,
    input wire logic [31:0] sys_addr,
    input wire logic        sys_done,
    input wire logic        sys_err,
    input wire logic [7:0]  mem_cs_n,
    input wire logic        mem_we_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_doe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    cs_onehot_a: assert property ($onehot0(~mem_cs_n))
        else $error("more than one bank select low");
    strobe_excl_a: assert property (mem_we_n || mem_oe_n)
        else $error("write and read strobes low together");
    we_in_bank_a: assert property (!mem_we_n
        |-> mem_cs_n != 8'hff && mem_doe)
        else $error("write strobe outside a driven bank access");
    oe_no_drive_a: assert property (!mem_oe_n |-> !mem_doe)
        else $error("data driven during a read strobe");
    bank_decode_a: assert property (sys_req && mem_cs_n != 8'hff
        |-> ~mem_cs_n == 8'h1 << sys_addr[28:26] && sys_addr[31:29] == 3'h2)
        else $error("bank select does not match the address window");
    refused_quiet_a: assert property (sys_done && sys_err
        |-> mem_cs_n == 8'hff && $past(mem_cs_n) == 8'hff)
        else $error("refused access produced a bank select");
    err_with_done_a: assert property (sys_err |-> sys_done)
        else $error("error flag without completion");
    done_pulse_a: assert property (sys_done |=> !sys_done)
        else $error("completion longer than one cycle");
    done_bound_a: assert property ($rose(sys_req)
        |-> ##[1:700] sys_done)
        else $error("access never completed");
    idle_quiet_a: assert property (!sys_req && !$past(sys_req)
        |-> mem_cs_n == 8'hff && mem_we_n && mem_oe_n)
        else $error("external strobe with no access pending");
endmodule // smc_checker
bind static_memory_bank_controller smc_checker chk (.pclk, .presetn,
    .sys_req, .sys_addr, .sys_done, .sys_err, .mem_cs_n, .mem_we_n,
    .mem_oe_n, .mem_doe);
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the static memory bank controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        sys_req = 1'b0;
    logic        sys_write = 1'b0;
    logic [31:0] sys_addr = 32'h0;
    logic [3:0]  sys_be = 4'h0;
    logic [31:0] sys_wdata = 32'h0;
    logic        pready, pslverr, irq, sys_done, sys_err;
    logic        mem_we_n, mem_oe_n, mem_doe, e_r, s_err;
    logic [31:0] prdata, sys_rdata, mem_dout, mem_din, q_r, s_rd;
    logic [7:0]  mem_cs_n;
    logic [3:0]  byte_lane_select_n;
    logic [25:0] mem_addr;
    int          s_cyc, we_cnt = 0, miscompares = 0, checked = 0;
    static_memory_bank_controller dut (.pclk, .presetn, .clk_en(1'b1),
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .irq, .sys_req, .sys_write, .sys_addr, .sys_be,
        .sys_wdata, .sys_done, .sys_err, .sys_rdata, .mem_cs_n,
        .byte_lane_select_n, .mem_we_n, .mem_oe_n, .mem_addr,
        .mem_dout, .mem_doe, .mem_din);
    sram_model mem (.pclk, .mem_cs_n, .byte_lane_select_n, .mem_we_n,
        .mem_oe_n, .mem_addr, .mem_dout, .mem_din);
    initial
        forever #2.5 pclk = ~pclk;
    always @(posedge pclk)
        if (mem_we_n === 1'b0)
            we_cnt++;
    task automatic finish_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic hang();
        miscompares++;
        finish_test();
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 50)
            hang();
        q_r = prdata;
        e_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // The request is held until the completion pulse, then dropped at once.
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        int n;
        @(posedge pclk);
        sys_req <= 1'b1;
        sys_write <= w;
        sys_addr <= a;
        sys_be <= be;
        sys_wdata <= d;
        for (n = 1; n < 700; n++)
        begin
            @(posedge pclk);
            if (sys_done === 1'b1)
                break;
        end
        if (n == 700)
            hang();
        s_cyc = n;
        s_err = sys_err;
        s_rd = sys_rdata;
        sys_req <= 1'b0;
    endtask
    task automatic chk_irq(input logic x);
        @(negedge pclk);
        cmp({31'h0, irq}, {31'h0, x});
    endtask
    function automatic logic [11:0] ra(input int b, input logic [11:0] o);
        return 12'(b) * smc_pkg::BANK_STRIDE + o;
    endfunction
    task automatic set_bank(input int b, input logic [31:0] c, rw, dl);
        wr(ra(b, smc_pkg::OFF_RDWAIT), rw);
        wr(ra(b, smc_pkg::OFF_WRWAIT), 32'h5);
        wr(ra(b, smc_pkg::OFF_OEDLY), dl);
        wr(ra(b, smc_pkg::OFF_WEDLY), dl);
        wr(ra(b, smc_pkg::OFF_IDLE), 32'h0);
        wr(ra(b, smc_pkg::OFF_CFG), c);
    endtask
    task automatic t_reset();
        logic [31:0] ex [7] = '{32'hf, 32'h1f, 32'h1f, 32'h0, 32'h1,
                               32'h80, 32'h0};
        for (int i = 0; i < 7; i++)
        begin
            rd(12'(4 * i));
            cmp(q_r, ex[i]);
        end
        rd(ra(1, smc_pkg::OFF_CFG));
        cmp(q_r, 32'h0);
        rd(ra(2, smc_pkg::OFF_CFG));
        cmp(q_r, 32'h40);
        wr(ra(7, smc_pkg::OFF_IDLE), 32'hffff_fff0);
        rd(ra(7, smc_pkg::OFF_IDLE));
        cmp(q_r, 32'h0);
        rd(ra(7, smc_pkg::OFF_RDWAIT));
        cmp(q_r, 32'h1f);
        rd(12'h0f0);
        cmp({31'h0, e_r}, 32'h1);
    endtask
    task automatic t_widths();
        logic [31:0] cfg [3] = '{32'h81, 32'h41, 32'h00};
        int parts [3] = '{1, 2, 4};
        int d;
        logic [31:0] a;
        for (int i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 1 : 0;
            a = 32'h4000_0040 + (32'(3 + i) << 26);
            set_bank(3 + i, cfg[i], 32'(2 + i), 32'(d));
            acc(1'b1, a, 4'hf, 32'h1122_3344);
            cmp(32'(s_cyc), 32'(parts[i] * (8 + d) + 2));
            acc(1'b0, a, 4'hf, 32'h0);
            cmp(32'(s_cyc), 32'(parts[i] * (5 + i + d) + 2));
            cmp(s_rd, 32'h1122_3344);
            acc(1'b1, a, 4'h4, 32'haabb_ccdd);
            acc(1'b0, a, 4'hf, 32'h0);
            cmp(s_rd, 32'h11bb_3344);
        end
    endtask
    task automatic t_turn();
        wr(ra(3, smc_pkg::OFF_IDLE), 32'h2);
        acc(1'b0, 32'h4c00_0040, 4'hf, 32'h0);
        acc(1'b1, 32'h4c00_0040, 4'hf, 32'h5566_7788);
        cmp(32'(s_cyc), 32'd14);
        acc(1'b1, 32'h4c00_0040, 4'hf, 32'h5566_7788);
        cmp(32'(s_cyc), 32'd11);
    endtask
    task automatic t_protect();
        wr(ra(6, smc_pkg::OFF_CFG), 32'h88);
        wr(smc_pkg::OFF_IRQ_MASK, 32'hff);
        we_cnt = 0;
        acc(1'b1, 32'h5800_0010, 4'hf, 32'h1);
        cmp({31'h0, s_err}, 32'h1);
        cmp(32'(we_cnt), 32'h0);
        rd(ra(6, smc_pkg::OFF_STAT));
        cmp(q_r, 32'h2);
        chk_irq(1'b1);
        wr(smc_pkg::OFF_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        wr(ra(6, smc_pkg::OFF_STAT), 32'h2);
        wr(smc_pkg::OFF_IRQ_STAT, 32'hff);
        wr(smc_pkg::OFF_IRQ_MASK, 32'hff);
        chk_irq(1'b0);
        rd(ra(6, smc_pkg::OFF_STAT));
        cmp(q_r, 32'h0);
        acc(1'b1, 32'h5800_0010, 4'hf, 32'h1);
        chk_irq(1'b1);
        wr(smc_pkg::OFF_IRQ_STAT, 32'h40);
        chk_irq(1'b0);
        acc(1'b0, 32'h5800_0010, 4'hf, 32'h0);
        cmp({31'h0, s_err}, 32'h0);
        acc(1'b0, 32'h6000_0000, 4'hf, 32'h0);
        cmp({31'h0, s_err}, 32'h1);
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_widths();
        t_turn();
        t_protect();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
